// ---- src/gcr_top.sv ----
`timescale 1ns/1ps
`include "gcr_consts.svh"

module gcr_top #(
	parameter int QS_CYCLES = `GCR_QS_CYCLES
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Gauge inputs, same clock domain
	input  wire gcr_pkg::gcr_meas_s meas,
	input  wire logic [15:0]        battery_status,
	input  wire logic               sleep_mode,
	input  wire logic               charge_fault,
	// Broadcast port to SMBus master
	output gcr_pkg::gcr_msg_s       msg,
	output logic                    msg_valid,
	input  wire logic               msg_ready,
	// Gauge state
	output logic [15:0]             remaining_capacity_count,
	output logic                    terminate_discharge_alarm,
	output gcr_pkg::gcr_sel_e       charge_sel
);

	logic [31:0] ctrl, rates, sleep_per, ocv_lo, ocv_hi, chg_i, pre_i, pre_qual, thresh, taper;
	logic [31:0] qs_cnt;
	logic        qs_tick;
	logic [6:0]  bc_cnt, mid_cnt;
	logic        bc_tick, mid_tick;
	logic [15:0] slp_cnt;
	logic        apply;
	logic [33:0] sd_acc, ld_acc;
	logic [7:0]  pend;
	logic        pre_v, full, tap_seen, ot_done;
	logic [6:0]  mid_prev;
	gcr_pkg::gcr_bc_e bc_st;

	wire logic [15:0] ocv_quarter        = ocv_lo[15:0];
	wire logic [15:0] ocv_half           = ocv_lo[31:16];
	wire logic [15:0] ocv_three_quarter  = ocv_hi[15:0];
	wire logic [15:0] fcc                = ocv_hi[31:16];
	wire logic [15:0] lowest_discharge_threshold = thresh[15:0];
	wire logic [15:0] filter_ma          = thresh[31:16];
	wire logic        continuous_ocv_correction_enable = ctrl[`GCR_CTRL_CONT];
	wire logic        one_time_ocv_correction_enable   = ctrl[`GCR_CTRL_ONCE];
	wire logic        wr = psel && penable && pready && pwrite;

	////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state so read data comes from a flop

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && penable && !pready;

	// Read data and error answer, latched as pready rises
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (psel && penable && !pready)
		begin
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			unique case (paddr)
				`GCR_OFF_CTRL:     prdata <= ctrl;
				`GCR_OFF_RATES:    prdata <= rates;
				`GCR_OFF_SLEEP:    prdata <= sleep_per;
				`GCR_OFF_OCV_LO:   prdata <= ocv_lo;
				`GCR_OFF_OCV_HI:   prdata <= ocv_hi;
				`GCR_OFF_CHG_I:    prdata <= chg_i;
				`GCR_OFF_PRE_I:    prdata <= pre_i;
				`GCR_OFF_PRE_QUAL: prdata <= pre_qual;
				`GCR_OFF_THRESH:   prdata <= thresh;
				`GCR_OFF_TAPER:    prdata <= taper;
				`GCR_OFF_RM:       prdata <= {16'h0000, remaining_capacity_count};
				`GCR_OFF_STATUS:   prdata <= {26'h0000000, mid_prev != 7'h00, full, pre_v,
					terminate_discharge_alarm, charge_sel};
				default:           pslverr <= 1'b1;
			endcase
		end

	// Configuration writes; unmapped writes are dropped with an error
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl <= `GCR_RST_CTRL;
			rates <= `GCR_RST_WORD;
			sleep_per <= `GCR_RST_WORD;
			ocv_lo <= `GCR_RST_WORD;
			ocv_hi <= `GCR_RST_WORD;
			chg_i <= `GCR_RST_WORD;
			pre_i <= `GCR_RST_WORD;
			pre_qual <= `GCR_RST_WORD;
			thresh <= `GCR_RST_WORD;
			taper <= `GCR_RST_WORD;
		end
		else if (wr)
		begin
			unique case (paddr)
				`GCR_OFF_CTRL:     ctrl <= {29'h00000000, pwdata[2:0]};
				`GCR_OFF_RATES:    rates <= {16'h0000, pwdata[15:0]};
				`GCR_OFF_SLEEP:    sleep_per <= {16'h0000, pwdata[15:0]};
				`GCR_OFF_OCV_LO:   ocv_lo <= pwdata;
				`GCR_OFF_OCV_HI:   ocv_hi <= pwdata;
				`GCR_OFF_CHG_I:    chg_i <= pwdata;
				`GCR_OFF_PRE_I:    pre_i <= pwdata;
				`GCR_OFF_PRE_QUAL: pre_qual <= {8'h00, pwdata[23:0]};
				`GCR_OFF_THRESH:   thresh <= pwdata;
				`GCR_OFF_TAPER:    taper <= {16'h0000, pwdata[15:0]};
				default:           ;
			endcase
		end

	////////////////////////////////////////////////////////////////////////
	// Time base: quarter second, 10 s and 20 s intervals

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			qs_cnt  <= 32'h0000_0000;
			qs_tick <= 1'b0;
		end
		else
		begin
			qs_tick <= qs_cnt == 32'(QS_CYCLES - 1);
			qs_cnt  <= (qs_cnt == 32'(QS_CYCLES - 1)) ? 32'h0000_0000 : qs_cnt + 32'h0000_0001;
		end

	// Interval counters advance on quarter-second ticks
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			bc_cnt <= 7'h00;
			mid_cnt <= 7'h00;
			bc_tick <= 1'b0;
			mid_tick <= 1'b0;
		end
		else
		begin
			bc_tick  <= qs_tick && bc_cnt == `GCR_BCAST_QS - 7'd1;
			mid_tick <= qs_tick && mid_cnt == `GCR_MID_QS - 7'd1;
			if (qs_tick)
			begin
				bc_cnt  <= (bc_cnt == `GCR_BCAST_QS - 7'd1) ? 7'h00 : bc_cnt + 7'h01;
				mid_cnt <= (mid_cnt == `GCR_MID_QS - 7'd1) ? 7'h00 : mid_cnt + 7'h01;
			end
		end

	// Asleep, the capacity is charged only once per programmed period plus one quarter second
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			slp_cnt <= 16'h0000;
		else if (qs_tick && sleep_mode)
			slp_cnt <= (slp_cnt >= sleep_per[15:0]) ? 16'h0000 : slp_cnt + 16'h0001;
		else if (!sleep_mode)
			slp_cnt <= 16'h0000;

	assign apply = qs_tick && (!sleep_mode || slp_cnt >= sleep_per[15:0]);

	////////////////////////////////////////////////////////////////////////
	// Self-discharge and load accumulators; whole mAh go to a pending count

	logic [7:0]  sd_mult;
	logic [33:0] sd_sum, ld_sum;
	logic        sd_dec, ld_dec, ld_on;
	logic [15:0] cur_abs;

	// Temperature band picks 1/4 .. 32 as 1 .. 128 in quarter units
	always_comb
	begin
		sd_mult = 8'd128;
		if (meas.temp_c < 8'sd10)
			sd_mult = 8'd1;
		else if (meas.temp_c < 8'sd20)
			sd_mult = 8'd2;
		else if (meas.temp_c < 8'sd30)
			sd_mult = 8'd4;
		else if (meas.temp_c < 8'sd40)
			sd_mult = 8'd8;
		else if (meas.temp_c < 8'sd50)
			sd_mult = 8'd16;
		else if (meas.temp_c < 8'sd60)
			sd_mult = 8'd32;
		else if (meas.temp_c < 8'sd70)
			sd_mult = 8'd64;
	end

	assign cur_abs = meas.cur_ma[15] ? 16'(-meas.cur_ma) : meas.cur_ma;
	assign ld_on   = ctrl[`GCR_CTRL_LOAD] && cur_abs < filter_ma;
	assign sd_sum  = sd_acc + 34'(fcc * rates[7:0] * sd_mult);
	assign ld_sum  = ld_acc + (ld_on ? 34'(rates[15:8] * `GCR_LD_STEP_UA) : 34'h0);
	assign sd_dec  = sd_sum >= `GCR_SD_DIV;
	assign ld_dec  = ld_sum >= `GCR_LD_DIV;

	// One mAh at most per accumulator per tick; rates above that saturate
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sd_acc <= 34'h0;
			ld_acc <= 34'h0;
		end
		else if (qs_tick)
		begin
			sd_acc <= sd_dec ? sd_sum - `GCR_SD_DIV : sd_sum;
			ld_acc <= ld_dec ? ld_sum - `GCR_LD_DIV : ld_sum;
		end

	// Pending debt is held while asleep and charged on the next apply
	logic [7:0] pend_sum;
	assign pend_sum = pend + {7'h00, sd_dec} + {7'h00, ld_dec};

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			pend <= 8'h00;
		else if (apply)
			pend <= 8'h00;
		else if (qs_tick && pend != 8'hFF)
			pend <= pend_sum;

	////////////////////////////////////////////////////////////////////////
	// Midrange correction against the three open-circuit levels

	logic [31:0] rm100, f13, f37, f38, f62, f63, f87;
	logic [6:0]  mid_tgt;
	logic        mid_ok, mid_apply, ot_try;
	assign rm100 = remaining_capacity_count * 32'd100;
	assign f13 = fcc * 32'd13;
	assign f37 = fcc * 32'd37;
	assign f38 = fcc * 32'd38;
	assign f62 = fcc * 32'd62;
	assign f63 = fcc * 32'd63;
	assign f87 = fcc * 32'd87;

	// Highest level wins when several disagree
	always_comb
	begin
		mid_tgt = 7'd0;
		if ((meas.volt_mv >= ocv_three_quarter && rm100 <= f63) || (meas.volt_mv < ocv_three_quarter && rm100 >= f87))
			mid_tgt = 7'd75;
		else if ((meas.volt_mv >= ocv_half && rm100 <= f38) || (meas.volt_mv < ocv_half && rm100 >= f62))
			mid_tgt = 7'd50;
		else if ((meas.volt_mv >= ocv_quarter && rm100 <= f13) || (meas.volt_mv < ocv_quarter && rm100 >= f37))
			mid_tgt = 7'd25;
	end

	assign mid_ok = meas.temp_c >= `GCR_MID_T_LO && meas.temp_c <= `GCR_MID_T_HI
		&& meas.cur_ma >= `GCR_MID_I_LO && meas.cur_ma <= 16'sd0
		&& meas.avg_ma >= `GCR_MID_I_LO && meas.avg_ma <= 16'sd0;
	assign ot_try = qs_tick && !ot_done && one_time_ocv_correction_enable
		&& !continuous_ocv_correction_enable;
	assign mid_apply = (mid_tick && continuous_ocv_correction_enable && mid_ok && mid_tgt != 7'd0
		&& mid_tgt == mid_prev) || (ot_try && mid_ok && mid_tgt != 7'd0);

	// Detection history; a miss or a changed target restarts confirmation
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mid_prev <= 7'd0;
			ot_done  <= 1'b0;
		end
		else
		begin
			if (qs_tick)
				ot_done <= 1'b1;
			if (mid_tick)
				mid_prev <= (continuous_ocv_correction_enable && mid_ok && !mid_apply) ? mid_tgt : 7'd0;
		end

	// Remaining capacity: software load, correction, then drain
	logic [31:0] mid_rm;
	assign mid_rm = (fcc * mid_tgt) / 32'd100;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			remaining_capacity_count <= 16'h0000;
		else if (wr && paddr == `GCR_OFF_RM)
			remaining_capacity_count <= pwdata[15:0];
		else if (mid_apply)
			remaining_capacity_count <= mid_rm[15:0];
		else if (apply)
			remaining_capacity_count <= (remaining_capacity_count > {8'h00, pend_sum}) ?
				remaining_capacity_count - {8'h00, pend_sum} : 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Charge qualification and current choice

	logic tda_now;
	assign tda_now = meas.min_cell_mv <= lowest_discharge_threshold;

	// Precharge latch; the set side wins over the release
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pre_v <= 1'b0;
			terminate_discharge_alarm <= 1'b0;
		end
		else
		begin
			terminate_discharge_alarm <= tda_now;
			if (meas.volt_mv < pre_qual[15:0] || tda_now)
				pre_v <= 1'b1;
			else if (meas.volt_mv > pre_qual[15:0])
				pre_v <= 1'b0;
		end

	// Taper must be seen on two successive 10 s checks in the voltage phase
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			tap_seen <= 1'b0;
			full <= 1'b0;
		end
		else if (bc_tick)
		begin
			if (meas.volt_mv + `GCR_CV_MARGIN_MV >= chg_i[31:16] && meas.cur_ma > 16'sd0
				&& meas.cur_ma < $signed(taper[15:0]))
			begin
				tap_seen <= 1'b1;
				full <= full || tap_seen;
			end
			else
			begin
				tap_seen <= 1'b0;
				full <= full && !meas.cur_ma[15];
			end
		end

	// Zero on fault or cold, then precharge, then maintenance, then fast
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			charge_sel <= gcr_pkg::GCR_SEL_ZERO;
		else if (charge_fault || meas.temp_c < 8'sd0)
			charge_sel <= gcr_pkg::GCR_SEL_ZERO;
		else if (pre_v || meas.temp_c < $signed(pre_qual[23:16]))
			charge_sel <= gcr_pkg::GCR_SEL_PRE;
		else if (full)
			charge_sel <= gcr_pkg::GCR_SEL_MAINT;
		else
			charge_sel <= gcr_pkg::GCR_SEL_FAST;

	////////////////////////////////////////////////////////////////////////
	// Broadcast sequencer: requests every 10 s, alarms while bits are set

	logic [15:0] cc_val;
	always_comb
		unique case (charge_sel)
			gcr_pkg::GCR_SEL_ZERO:  cc_val = 16'h0000;
			gcr_pkg::GCR_SEL_PRE:   cc_val = pre_i[15:0];
			gcr_pkg::GCR_SEL_MAINT: cc_val = chg_i[15:0];
			gcr_pkg::GCR_SEL_FAST:  cc_val = pre_i[31:16];
		endcase

	wire logic host_al = battery_status[15:8] != 8'h00;
	wire logic chg_al  = battery_status[15:12] != 4'h0;

	// Each message holds until the SMBus master takes it
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			bc_st <= gcr_pkg::GCR_BC_IDLE;
			msg <= '0;
			msg_valid <= 1'b0;
		end
		else
			unique case (bc_st)
				gcr_pkg::GCR_BC_IDLE:
					if (bc_tick)
					begin
						bc_st <= gcr_pkg::GCR_BC_CUR;
						msg <= '{1'b0, `GCR_CMD_CUR, cc_val};
						msg_valid <= 1'b1;
					end
				gcr_pkg::GCR_BC_CUR:
					if (msg_ready)
					begin
						bc_st <= gcr_pkg::GCR_BC_VOLT;
						msg <= '{1'b0, `GCR_CMD_VOLT, chg_i[31:16]};
					end
				gcr_pkg::GCR_BC_VOLT:
					if (msg_ready)
					begin
						bc_st <= host_al ? gcr_pkg::GCR_BC_AHOST : gcr_pkg::GCR_BC_IDLE;
						msg <= '{1'b1, `GCR_CMD_ALARM, battery_status};
						msg_valid <= host_al;
					end
				gcr_pkg::GCR_BC_AHOST:
					if (msg_ready)
					begin
						bc_st <= chg_al ? gcr_pkg::GCR_BC_ACHG : gcr_pkg::GCR_BC_IDLE;
						msg <= '{1'b0, `GCR_CMD_ALARM, battery_status};
						msg_valid <= chg_al;
					end
				gcr_pkg::GCR_BC_ACHG:
					if (msg_ready)
					begin
						bc_st <= gcr_pkg::GCR_BC_IDLE;
						msg_valid <= 1'b0;
					end
				default:
				begin
					bc_st <= gcr_pkg::GCR_BC_IDLE;
					msg_valid <= 1'b0;
				end
			endcase

	////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_req_cur;
		msg_valid && msg.cmd == `GCR_CMD_CUR && !msg.to_host;
	endsequence

	property p_bcast_start;
		@(posedge pclk) disable iff (!presetn) bc_tick && bc_st == gcr_pkg::GCR_BC_IDLE |=> s_req_cur;
	endproperty
	a_bcast_start: assert property (p_bcast_start) else $error("current request not started");

	property p_msg_hold;
		@(posedge pclk) disable iff (!presetn) msg_valid && !msg_ready |=> msg_valid && $stable(msg);
	endproperty
	a_msg_hold: assert property (p_msg_hold) else $error("message dropped before taken");

	property p_alarm_host;
		@(posedge pclk) disable iff (!presetn)
			msg_valid && msg.to_host |-> msg.cmd == `GCR_CMD_ALARM && msg.data[15:8] != 8'h00;
	endproperty
	a_alarm_host: assert property (p_alarm_host) else $error("host alarm without alarm bits");

	property p_alarm_chg;
		@(posedge pclk) disable iff (!presetn)
			msg_valid && !msg.to_host && msg.cmd == `GCR_CMD_ALARM |-> msg.data[15:12] != 4'h0;
	endproperty
	a_alarm_chg: assert property (p_alarm_chg) else $error("charger alarm without bits 12-15");

	property p_mid_window;
		@(posedge pclk) disable iff (!presetn)
			mid_apply |-> meas.temp_c >= 8'sd19 && meas.temp_c <= 8'sd31 && meas.avg_ma <= 16'sd0;
	endproperty
	a_mid_window: assert property (p_mid_window) else $error("correction outside window");

	property p_mid_result;
		@(posedge pclk) disable iff (!presetn)
			mid_apply && !(wr && paddr == `GCR_OFF_RM) |=> remaining_capacity_count == $past(mid_rm[15:0]);
	endproperty
	a_mid_result: assert property (p_mid_result) else $error("correction value not loaded");

	property p_rm_still;
		@(posedge pclk) disable iff (!presetn)
			!apply && !mid_apply && !wr |=> remaining_capacity_count == $past(remaining_capacity_count);
	endproperty
	a_rm_still: assert property (p_rm_still) else $error("capacity changed off tick");

	property p_tda;
		@(posedge pclk) disable iff (!presetn) tda_now |=> terminate_discharge_alarm && pre_v;
	endproperty
	a_tda: assert property (p_tda) else $error("lowest threshold not flagged");

	property p_pre_sel;
		@(posedge pclk) disable iff (!presetn)
			pre_v && !charge_fault && meas.temp_c >= 8'sd0 |=> charge_sel == gcr_pkg::GCR_SEL_PRE;
	endproperty
	a_pre_sel: assert property (p_pre_sel) else $error("precharge not selected");

	property p_fast_temp;
		@(posedge pclk) disable iff (!presetn)
			charge_sel == gcr_pkg::GCR_SEL_FAST |-> $past(meas.temp_c) >= $signed($past(pre_qual[23:16]));
	endproperty
	a_fast_temp: assert property (p_fast_temp) else $error("fast charge below precharge temp");

endmodule : gcr_top

// ---- src/gcr_consts.svh ----
// Contract
// - Subtract self-discharge from remaining capacity each quarter second awake, per sleep period asleep; code: every sleep_per plus one quarter second.
// - Self-discharge rate doubles per 10 degrees above 25, halves per 10 below.
// - Multiplier bands: below 10 quarter, then half, 1, 2, 4, 8, 16, 32 from 70.
// - When enabled, deduct constant-load compensation too whenever current is below filter threshold.
// - Load compensation rate is configurable, 0 to 765 microamps in 3 microamp steps.
// - Midrange corrections need the continuous or the one-time enable; levels at 25, 50, 75 percent voltages.
// - Correct only at 19..31 degrees with current and average current in -64..0 mA.
// - Apply a correction after two successive 20 second detections; repeat whenever allowed.
// - One-time enable without continuous: single correction attempt after reset, no confirmation.
// - Force 75 percent: voltage at/above level with charge <=63, or below with >=87.
// - Force 50 (38/62) or 25 (13/37) percent by the same voltage and bound test.
// - Send charging current and voltage requests to the charger every 10 seconds.
// - Requested current is fast, maintenance, precharge or zero, by state and conditions.
// - Constant current then voltage profile; termination from current taper in voltage phase.
// - Send alarm warning to host while any status bit 8..15 is set.
// - Also send alarm warning to charger while any status bit 12..15 is set.
// - Repeat alarm warnings every 10 seconds until the alarm bits clear.
// - Precharge on low voltage or lowest threshold; hold until voltage above and threshold gone.
// - Precharge between 0 degrees and precharge temperature; fast only at or above it.
// - Lowest discharge threshold is per-cell on the lowest cell; reaching it sets terminate alarm.
`ifndef GCR_CONSTS_SVH
`define GCR_CONSTS_SVH

// Register byte offsets
`define GCR_OFF_CTRL      8'h00
`define GCR_OFF_RATES     8'h04
`define GCR_OFF_SLEEP     8'h08
`define GCR_OFF_OCV_LO    8'h0C
`define GCR_OFF_OCV_HI    8'h10
`define GCR_OFF_CHG_I     8'h14
`define GCR_OFF_PRE_I     8'h18
`define GCR_OFF_PRE_QUAL  8'h1C
`define GCR_OFF_THRESH    8'h20
`define GCR_OFF_RM        8'h24
`define GCR_OFF_TAPER     8'h28
`define GCR_OFF_STATUS    8'h2C

// Control bit positions
`define GCR_CTRL_CONT     0
`define GCR_CTRL_ONCE     1
`define GCR_CTRL_LOAD     2

// Reset values
`define GCR_RST_CTRL      32'h0000_0000
`define GCR_RST_WORD      32'h0000_0000

// Timing
`define GCR_CLK_NS        100
`define GCR_QS_MS         250
`define GCR_QS_CYCLES     (`GCR_QS_MS * 1000000 / `GCR_CLK_NS)
`define GCR_BCAST_QS      7'd40
`define GCR_MID_QS        7'd80

// Accumulator divisors: 0.1 %/day with 4x multiplier; uA*quarter-second per mAh
`define GCR_SD_DIV        34'd1382400000
`define GCR_LD_DIV        34'd14400000
`define GCR_LD_STEP_UA    8'd3

// Midrange window and voltage-phase margin
`define GCR_MID_T_LO      8'sd19
`define GCR_MID_T_HI      8'sd31
`define GCR_MID_I_LO      (-16'sd64)
`define GCR_CV_MARGIN_MV  16'd100

// SBS command codes
`define GCR_CMD_CUR       8'h14
`define GCR_CMD_VOLT      8'h15
`define GCR_CMD_ALARM     8'h16

`endif

// ---- src/gcr_pkg.sv ----
package gcr_pkg;

	// Charge current selection
	typedef enum logic [1:0] {
		GCR_SEL_ZERO  = 2'b00,
		GCR_SEL_PRE   = 2'b01,
		GCR_SEL_MAINT = 2'b10,
		GCR_SEL_FAST  = 2'b11
	} gcr_sel_e;

	// Broadcast sequencer
	typedef enum logic [2:0] {
		GCR_BC_IDLE  = 3'b000,
		GCR_BC_CUR   = 3'b001,
		GCR_BC_VOLT  = 3'b010,
		GCR_BC_AHOST = 3'b011,
		GCR_BC_ACHG  = 3'b100
	} gcr_bc_e;

	// Measurements from the converters
	typedef struct packed {
		logic signed [7:0]  temp_c;
		logic        [15:0] volt_mv;
		logic signed [15:0] cur_ma;
		logic signed [15:0] avg_ma;
		logic        [15:0] min_cell_mv;
	} gcr_meas_s;

	// One SMBus broadcast; to_host low means charger
	typedef struct packed {
		logic        to_host;
		logic [7:0]  cmd;
		logic [15:0] data;
	} gcr_msg_s;

endpackage : gcr_pkg

// ---- tb/gcr_host_model.sv ----
`timescale 1ns/1ps

module gcr_host_model (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Broadcast port
	input  wire gcr_pkg::gcr_msg_s msg,
	input  wire logic              msg_valid,
	output logic                   msg_ready,
	// Stall control and capture
	input  wire logic              slow,
	output gcr_pkg::gcr_msg_s      last_msg,
	output logic                   took
);

	////////////////////////////////////////////////////////////////////////////////
	// Slow mode refuses every other cycle, like a bus busy with other traffic
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			msg_ready <= 1'b0;
		else
			msg_ready <= slow ? ~msg_ready : 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// A message counts only at the edge where both sides agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			took     <= 1'b0;
			last_msg <= '0;
		end
		else
		begin
			took <= msg_valid && msg_ready;
			if (msg_valid && msg_ready)
				last_msg <= msg;
		end
	end

endmodule : gcr_host_model

// ---- tb/gcr_top_tb.sv ----
`timescale 1ns/1ps
`include "gcr_consts.svh"

module gcr_top_tb;
	localparam int QS = 40;
	localparam int BC = QS * 40;

	logic               pclk           = 1'b0;
	logic               presetn        = 1'b0;
	logic               psel           = 1'b0;
	logic               penable        = 1'b0;
	logic               pwrite         = 1'b0;
	logic [7:0]         paddr          = 8'h00;
	logic [31:0]        pwdata         = 32'h0;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	gcr_pkg::gcr_meas_s meas           = {8'sh19, 16'h2CEC, 16'sh0, 16'sh0, 16'h0DAC};
	logic [15:0]        battery_status = 16'h0;
	logic               charge_fault   = 1'b0;
	logic               sleep_mode     = 1'b0;
	logic               slow           = 1'b0;
	gcr_pkg::gcr_msg_s  msg;
	gcr_pkg::gcr_msg_s  last_msg;
	gcr_pkg::gcr_msg_s  log_q[$];
	logic               msg_valid;
	logic               msg_ready;
	logic               took;
	logic [15:0]        remaining_capacity_count;
	logic               terminate_discharge_alarm;
	gcr_pkg::gcr_sel_e  charge_sel;
	logic [31:0]        rq;
	logic               re;
	int                 n_fail         = 0;
	int                 cmp_count      = 0;

	gcr_top #(.QS_CYCLES(QS)) u_gcr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.meas(meas), .battery_status(battery_status), .sleep_mode(sleep_mode), .charge_fault(charge_fault),
		.msg(msg), .msg_valid(msg_valid), .msg_ready(msg_ready),
		.remaining_capacity_count(remaining_capacity_count),
		.terminate_discharge_alarm(terminate_discharge_alarm), .charge_sel(charge_sel));

	gcr_host_model u_gcr_host_model (.pclk(pclk), .presetn(presetn), .msg(msg), .msg_valid(msg_valid),
		.msg_ready(msg_ready), .slow(slow), .last_msg(last_msg), .took(took));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and message log
	always #50 pclk = ~pclk;

	always @(posedge pclk)
		if (took)
			log_q.push_back(last_msg);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer, entered just after a rising edge; waits for pready
	// An idle edge follows, so the next call never re-drives psel in the same step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rq = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// One-time correction lands on the first quarter-second tick after reset
	task automatic t_once();
		apb(1'b1, `GCR_OFF_OCV_LO, 32'h2AF8_2710);
		apb(1'b1, `GCR_OFF_OCV_HI, 32'h03E8_2EE0);
		apb(1'b1, `GCR_OFF_RM, 32'h0000_0384);
		apb(1'b1, `GCR_OFF_CTRL, 32'h0000_0002);
		repeat (QS * 3) @(posedge pclk);
		apb(1'b0, `GCR_OFF_RM, 32'h0);
		check(rq, 32'h0000_02EE);
		check({16'h0, remaining_capacity_count}, 32'h0000_02EE);
	endtask : t_once

	// One full broadcast window after the status has settled
	task automatic t_bc(input logic [15:0] st, input int n_exp, input logic sl);
		battery_status <= st;
		slow           <= sl;
		repeat (BC + 100) @(posedge pclk);
		log_q.delete();
		repeat (BC) @(posedge pclk);
		check(log_q.size(), n_exp);
		check(32'(log_q[0]), 32'h0014_07D0);
		check(32'(log_q[1]), 32'h0015_3138);
		if (n_exp > 2)
			check(32'(log_q[2]), {7'h0, 9'h116, st});
		if (n_exp > 3)
			check(32'(log_q[3][24:16]), 32'h0000_0016);
	endtask : t_bc

	task automatic t_case(input logic [7:0] t, input logic [15:0] v, input logic [15:0] c, input logic f,
		input gcr_pkg::gcr_sel_e s);
		meas.temp_c      <= t;
		meas.volt_mv     <= v;
		meas.min_cell_mv <= c;
		charge_fault     <= f;
		repeat (BC + 100) @(posedge pclk);
		check({30'h0, charge_sel}, {30'h0, s});
		check({31'h0, terminate_discharge_alarm}, {31'h0, c <= 16'h0BB8});
	endtask : t_case

	// Continuous correction: one 20 s check only arms it, the next applies half of capacity
	task automatic t_cont();
		apb(1'b1, `GCR_OFF_RM, 32'h0000_012C);
		apb(1'b1, `GCR_OFF_CTRL, 32'h0000_0001);
		repeat (QS * 40) @(posedge pclk);
		check({16'h0, remaining_capacity_count}, 32'h0000_012C);
		repeat (QS * 120 + 20) @(posedge pclk);
		check({16'h0, remaining_capacity_count}, 32'h0000_01F4);
	endtask : t_cont

	// Hot pack at 32x loses half a mAh per quarter second; asleep it comes off in lumps
	task automatic t_drain(input logic sl, input int n_chg);
		logic [15:0] prev;
		logic [15:0] first;
		int          n;
		n = 0;
		sleep_mode <= sl;
		repeat (QS * 8) @(posedge pclk);
		prev  = remaining_capacity_count;
		first = prev;
		repeat (QS * 20)
		begin
			@(posedge pclk);
			if (remaining_capacity_count != prev)
				n++;
			prev = remaining_capacity_count;
		end
		check(first - prev, 32'd10);
		check(n, n_chg);
	endtask : t_drain

	task automatic wrap_up();
		$display("counts: %0d mismatches, %0d comparisons", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_once();
		apb(1'b1, `GCR_OFF_CHG_I, 32'h3138_0064);
		apb(1'b1, `GCR_OFF_PRE_I, 32'h07D0_00C8);
		apb(1'b1, `GCR_OFF_PRE_QUAL, 32'h000A_2328);
		apb(1'b1, `GCR_OFF_THRESH, 32'h0000_0BB8);
		apb(1'b0, 8'hFC, 32'h0);
		check({re, rq[30:0]}, 32'h8000_0000);
		t_bc(16'h0000, 2, 1'b0);
		t_bc(16'h0100, 3, 1'b1);
		t_bc(16'hF000, 4, 1'b1);
		t_case(8'h19, 16'h2CEC, 16'h0DAC, 1'b0, gcr_pkg::GCR_SEL_FAST);
		t_case(8'h05, 16'h2CEC, 16'h0DAC, 1'b0, gcr_pkg::GCR_SEL_PRE);
		t_case(8'h19, 16'h1F40, 16'h0DAC, 1'b0, gcr_pkg::GCR_SEL_PRE);
		t_case(8'h19, 16'h2328, 16'h0DAC, 1'b0, gcr_pkg::GCR_SEL_PRE);
		t_case(8'h19, 16'h2CEC, 16'h0BB8, 1'b0, gcr_pkg::GCR_SEL_PRE);
		t_case(8'h19, 16'h2CEC, 16'h0DAC, 1'b1, gcr_pkg::GCR_SEL_ZERO);
		t_cont();
		meas.temp_c <= 8'sh46;
		apb(1'b1, `GCR_OFF_OCV_HI, 32'h5460_2EE0);
		apb(1'b1, `GCR_OFF_SLEEP, 32'h0000_0003);
		apb(1'b1, `GCR_OFF_RATES, 32'h0000_00FA);
		t_drain(1'b0, 10);
		t_drain(1'b1, 5);
		wrap_up();
	end

	// Watchdog, about twice the planned run
	initial
	begin
		#6000000;
		n_fail++;
		wrap_up();
	end

endmodule : gcr_top_tb
